//--- rtl/sdcp_top.sv
// Functional notes
// - Answer one fixed 7-bit slave address, chosen among three variants.
// - Command bit 0 picks update on STOP (0) or on sync command (1).
// - Command bit 1 requests power-down; data latches are kept.
// - Power-down change takes effect at a STOP condition, or at the ack of sync action 0.
// - Command bit 2 picks internal reference; bits 7 to 3 ignored.
// - Sync mode off: STOP copies input registers to output latches.
// - Sync mode on: update at ack rising edge of sync update command.
// - Low data byte gives code bits 7 to 0 in order.
// - High data byte bits 1 and 0 give code bits 9 and 8.
// - Send Byte loads only the command, data registers untouched.
// - START or STOP before last data ack drops data, keeps command.
// - START or STOP before command ack drops the partial command.
// - Recognise shared sync address as a quick command.
// - Sync action 0 clears all latches at its ack rising edge.
// - Sync action 1 updates only when sync mode is set.
// - Write Word sends low then high data byte, each acknowledged.
// - Acknowledge holds SDA low through the ninth clock high phase.
`timescale 1ns/1ns
`default_nettype none

module sdcp_top #(
  parameter int unsigned VARIANT = 0
) (
  // Clock and reset
  input  wire logic                         MCLK_I,
  input  wire logic                         RST_N_I,
  // Serial bus pins
  input  wire logic                         SCL_I,
  input  wire logic                         SDA_I,
  output logic                              SDA_O,
  output logic                              SDA_OE_O,
  // Converter controls
  output logic [sdcp_pkg::CODE_W-1:0]       DAC_CODE_O,
  output logic                              DAC_UPDATE_O,
  output logic                              POWER_DOWN_O,
  output logic                              INTERNAL_REF_O,
  output logic                              SYNC_MODE_O
);

  // ************************************************************
  // Address decoding
  // ************************************************************
  function automatic logic [6:0] own_addr(input int unsigned v);
    logic [6:0] a;
    a = sdcp_pkg::SLAVE_ADDR_V0;
    if (v == 1) begin
      a = sdcp_pkg::SLAVE_ADDR_V1;
    end else if (v == 2) begin
      a = sdcp_pkg::SLAVE_ADDR_V2;
    end
    return a;
  endfunction : own_addr

  localparam logic [6:0] MY_ADDR = own_addr(VARIANT);

  // Byte that follows once an ack has been given
  function automatic sdcp_pkg::sdcp_state_t next_state(
    input sdcp_pkg::sdcp_state_t s
  );
    sdcp_pkg::sdcp_state_t r;
    unique case (s)
      sdcp_pkg::ST_ADDR: begin
        r = sdcp_pkg::ST_CMD;
      end
      sdcp_pkg::ST_CMD: begin
        r = sdcp_pkg::ST_LOW;
      end
      sdcp_pkg::ST_LOW: begin
        r = sdcp_pkg::ST_HIGH;
      end
      default: begin
        r = sdcp_pkg::ST_SKIP;
      end
    endcase
    return r;
  endfunction : next_state

  function automatic sdcp_pkg::sdcp_cmd_t cmd_decode(input logic [7:0] b);
    sdcp_pkg::sdcp_cmd_t c;
    c.sync_update_mode          = b[sdcp_pkg::CMD_SYNC_BIT];
    c.power_down_request        = b[sdcp_pkg::CMD_PWRDN_BIT];
    c.internal_reference_select = b[sdcp_pkg::CMD_REF_BIT];
    return c;
  endfunction : cmd_decode

  // ************************************************************
  // Pin synchroniser and condition detector
  // ************************************************************
  sdcp_pkg::sdcp_bus_ev_t ev;

  sdcp_bus_sync u_sync (
    .clk_i   (MCLK_I),
    .rst_n_i (RST_N_I),
    .scl_i   (SCL_I),
    .sda_i   (SDA_I),
    .ev_o    (ev)
  );

  // ************************************************************
  // State
  // ************************************************************
  sdcp_pkg::sdcp_regs_t q;
  sdcp_pkg::sdcp_regs_t d;
  logic                 busy;

  assign busy = (q.state != sdcp_pkg::ST_IDLE) && (q.state != sdcp_pkg::ST_SKIP);

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    d     = q;
    d.upd = 1'h0;

    if (ev.start) begin
      // Uncommitted bytes vanish: commits only happen at ack
      d.state   = sdcp_pkg::ST_ADDR;
      d.ack     = 1'h0;
      d.bit_cnt = 4'h0;
      d.sda_oe  = 1'h0;
    end else if (ev.stop) begin
      d.state    = sdcp_pkg::ST_IDLE;
      d.ack      = 1'h0;
      d.bit_cnt  = 4'h0;
      d.sda_oe   = 1'h0;
      d.pwr_down = q.cmd.power_down_request;
      if (!q.cmd.sync_update_mode) begin
        d.code_out = q.code_in;
        d.upd      = 1'h1;
      end
    end else if (busy && ev.scl_rise) begin
      if (q.ack) begin
        unique case (q.state)
          sdcp_pkg::ST_CMD: begin
            d.cmd = cmd_decode(q.shift);
          end
          sdcp_pkg::ST_LOW: begin
            d.code_low_byte = q.shift;
          end
          sdcp_pkg::ST_HIGH: begin
            // Both bytes land together, only at the last ack
            d.code_in = {q.shift[sdcp_pkg::HI_CODE_W-1:0],
                         q.code_low_byte};
          end
          sdcp_pkg::ST_QUICK: begin
            if (q.group_action_bit == sdcp_pkg::ACTION_CLEAR) begin
              d.cmd           = sdcp_pkg::CMD_RESET;
              d.code_low_byte = 8'h00;
              d.code_in       = '0;
              d.code_out      = '0;
              d.pwr_down      = 1'h0;
            end else if (q.cmd.sync_update_mode) begin
              d.code_out = q.code_in;
              d.upd      = 1'h1;
            end
          end
          default: begin
          end
        endcase
      end else if (q.bit_cnt < sdcp_pkg::BYTE_BITS) begin
        d.shift   = {q.shift[6:0], ev.sda};
        d.bit_cnt = q.bit_cnt + 4'h1;
      end
    end else if (busy && ev.scl_fall) begin
      if (q.ack) begin
        // Release only after the ninth clock has gone low again
        d.ack     = 1'h0;
        d.sda_oe  = 1'h0;
        d.bit_cnt = 4'h0;
        d.state   = next_state(q.state);
      end else if (q.bit_cnt == sdcp_pkg::BYTE_BITS) begin
        unique case (q.state)
          sdcp_pkg::ST_ADDR: begin
            if (q.shift[7:1] == MY_ADDR && q.shift[0] == sdcp_pkg::RW_WRITE) begin
              d.ack    = 1'h1;
              d.sda_oe = 1'h1;
            end else if (q.shift[7:1] == sdcp_pkg::SYNC_ADDR) begin
              d.ack              = 1'h1;
              d.sda_oe           = 1'h1;
              d.group_action_bit = q.shift[0];
              d.state            = sdcp_pkg::ST_QUICK;
            end else begin
              d.state = sdcp_pkg::ST_SKIP;
            end
          end
          sdcp_pkg::ST_CMD,
          sdcp_pkg::ST_LOW,
          sdcp_pkg::ST_HIGH: begin
            d.ack    = 1'h1;
            d.sda_oe = 1'h1;
          end
          default: begin
            d.state = sdcp_pkg::ST_SKIP;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      q <= sdcp_pkg::REGS_RESET;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Open-drain: the data level is always low, only the enable moves
  assign SDA_O          = 1'h0;
  assign SDA_OE_O       = q.sda_oe;
  assign DAC_CODE_O     = q.code_out;
  assign DAC_UPDATE_O   = q.upd;
  assign POWER_DOWN_O   = q.pwr_down;
  assign INTERNAL_REF_O = q.cmd.internal_reference_select;
  assign SYNC_MODE_O    = q.cmd.sync_update_mode;

endmodule : sdcp_top

`default_nettype wire

//--- common/sdcp_pkg.sv
package sdcp_pkg;

  // ************************************************************
  // Address map of the serial port
  // ************************************************************
  localparam logic [6:0] SLAVE_ADDR_V0 = 7'h20;
  localparam logic [6:0] SLAVE_ADDR_V1 = 7'h21;
  localparam logic [6:0] SLAVE_ADDR_V2 = 7'h22;
  localparam logic [6:0] SYNC_ADDR     = 7'h7E;
  localparam logic       RW_WRITE      = 1'h0;
  localparam logic       ACTION_CLEAR  = 1'h0;

  // ************************************************************
  // Field layout of the received bytes
  // ************************************************************
  localparam int         CMD_SYNC_BIT  = 0;
  localparam int         CMD_PWRDN_BIT = 1;
  localparam int         CMD_REF_BIT   = 2;
  localparam int         CODE_W        = 10;
  localparam int         HI_CODE_W     = CODE_W - 8;
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_CMD   = 3'h3,
    ST_LOW   = 3'h2,
    ST_HIGH  = 3'h6,
    ST_QUICK = 3'h7,
    ST_SKIP  = 3'h5
  } sdcp_state_t;

  typedef struct packed {
    logic internal_reference_select;
    logic power_down_request;
    logic sync_update_mode;
  } sdcp_cmd_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } sdcp_bus_ev_t;

  typedef struct packed {
    sdcp_state_t       state;
    logic              ack;
    logic [3:0]        bit_cnt;
    logic [7:0]        shift;
    logic              group_action_bit;
    sdcp_cmd_t         cmd;
    logic [7:0]        code_low_byte;
    logic [CODE_W-1:0] code_in;
    logic [CODE_W-1:0] code_out;
    logic              pwr_down;
    logic              sda_oe;
    logic              upd;
  } sdcp_regs_t;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam sdcp_cmd_t CMD_RESET = '0;
  localparam sdcp_regs_t REGS_RESET = '{
    state:            ST_IDLE,
    ack:              1'h0,
    bit_cnt:          4'h0,
    shift:            8'h00,
    group_action_bit: 1'h0,
    cmd:              CMD_RESET,
    code_low_byte:    8'h00,
    code_in:          '0,
    code_out:         '0,
    pwr_down:         1'h0,
    sda_oe:           1'h0,
    upd:              1'h0
  };

endpackage : sdcp_pkg

//--- rtl/sdcp_bus_sync.sv
`timescale 1ns/1ns
`default_nettype none

module sdcp_bus_sync (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // Raw pins
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  // Events
  output var sdcp_pkg::sdcp_bus_ev_t ev_o
);

  // ************************************************************
  // Two-stage synchronisers, then one history stage
  // ************************************************************
  logic [1:0] pin;
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;

  assign pin = {scl_i, sda_i};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          meta_q[g] <= 1'h1;
          sync_q[g] <= 1'h1;
          prev_q[g] <= 1'h1;
        end else begin
          meta_q[g] <= pin[g];
          sync_q[g] <= meta_q[g];
          prev_q[g] <= sync_q[g];
        end
      end
    end
  endgenerate

  // Both lines share one latency, so their order is kept
  assign ev_o.scl      = sync_q[1];
  assign ev_o.sda      = sync_q[0];
  assign ev_o.scl_rise = sync_q[1] & ~prev_q[1];
  assign ev_o.scl_fall = ~sync_q[1] & prev_q[1];
  assign ev_o.start    = sync_q[1] & prev_q[1] & prev_q[0] & ~sync_q[0];
  assign ev_o.stop     = sync_q[1] & prev_q[1] & ~prev_q[0] & sync_q[0];

endmodule : sdcp_bus_sync

`default_nettype wire

//--- sim/sdcp_props.sv
`timescale 1ns/1ns
`default_nettype none

module sdcp_props (
  // Clock and reset
  input wire logic                        MCLK_I,
  input wire logic                        RST_N_I,
  // Bus pins
  input wire logic                        SCL_I,
  input wire logic                        SDA_I,
  input wire logic                        SDA_O,
  input wire logic                        SDA_OE_O,
  // Converter controls
  input wire logic [sdcp_pkg::CODE_W-1:0] DAC_CODE_O,
  input wire logic                        DAC_UPDATE_O,
  input wire logic                        POWER_DOWN_O,
  input wire logic                        INTERNAL_REF_O,
  input wire logic                        SYNC_MODE_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // ************************************************************
  // Bus side
  // ************************************************************
  AST_ACK_RISE: assert property ($rose(SDA_OE_O) |-> !SCL_I && !SDA_O)
    else $error("ack raised while clock high");
  AST_ACK_HOLD: assert property ($rose(SCL_I) && SDA_OE_O |=> SDA_OE_O [*8])
    else $error("ack dropped in clock high phase");

  // ************************************************************
  // Converter side
  // ************************************************************
  AST_PD_AT_STOP: assert property ($rose(POWER_DOWN_O) |-> SCL_I && SDA_I && !$past(SDA_I, 6))
    else $error("power-down entered outside a stop");
  AST_PD_FALL: assert property ($fell(POWER_DOWN_O) |-> SCL_I && (SDA_OE_O || SDA_I))
    else $error("power-down left outside stop or clear");
  AST_REF_AT_ACK: assert property ($changed(INTERNAL_REF_O) |-> SCL_I && SDA_OE_O)
    else $error("reference select changed outside an ack");
  AST_SYNC_AT_ACK: assert property ($changed(SYNC_MODE_O) |-> SCL_I && SDA_OE_O)
    else $error("sync mode changed outside an ack");
  AST_UPD_ONE: assert property (DAC_UPDATE_O |=> !DAC_UPDATE_O)
    else $error("update pulse too long");
  AST_UPD_WHEN: assert property (DAC_UPDATE_O |-> SCL_I &&
    (SYNC_MODE_O ? SDA_OE_O : SDA_I && !SDA_OE_O))
    else $error("update at the wrong bus moment");
  AST_CODE_CAUSE: assert property ($changed(DAC_CODE_O) |-> DAC_UPDATE_O || DAC_CODE_O == '0)
    else $error("code changed without update or clear");

  COV_SYNC_UPD: cover property (DAC_UPDATE_O && SDA_OE_O);
  COV_STOP_UPD: cover property (DAC_UPDATE_O && !SDA_OE_O);
  COV_PD: cover property ($rose(POWER_DOWN_O));
endmodule : sdcp_props

bind sdcp_top sdcp_props i_props (
  .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE_O(SDA_OE_O), .DAC_CODE_O(DAC_CODE_O), .DAC_UPDATE_O(DAC_UPDATE_O),
  .POWER_DOWN_O(POWER_DOWN_O), .INTERNAL_REF_O(INTERNAL_REF_O), .SYNC_MODE_O(SYNC_MODE_O)
);

`default_nettype wire

//--- sim/sdcp_host.sv
`timescale 1ns/1ns
`default_nettype none

module sdcp_host (
  // Clock
  input  wire logic clk_i,
  // Bus lines
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end

  // ************************************************************
  // Bus phases
  // ************************************************************
  // Quarter bit of 8 cycles, close to the 125 ns link period
  task automatic q();
    repeat (8) @(posedge clk_i);
  endtask : q

  // Usable mid-transfer too, so transfers can be chained
  task automatic start();
    sda_o <= 1'h1;
    q();
    scl_o <= 1'h1;
    q();
    sda_o <= 1'h0;
    q();
    scl_o <= 1'h0;
    q();
  endtask : start

  // Clock is left high: it stands still between frames
  task automatic stop();
    sda_o <= 1'h0;
    q();
    scl_o <= 1'h1;
    q();
    sda_o <= 1'h1;
    q();
  endtask : stop

  task automatic bitx(input logic b);
    sda_o <= b;
    q();
    scl_o <= 1'h1;
    q();
    q();
    scl_o <= 1'h0;
    q();
  endtask : bitx

  // Released line reads high through the pull-up
  task automatic xbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i]);
    end
    sda_o <= 1'h1;
    q();
    scl_o <= 1'h1;
    q();
    ack = !sda_i;
    q();
    scl_o <= 1'h0;
    q();
  endtask : xbyte
endmodule : sdcp_host

`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  localparam logic [6:0] ADDR = sdcp_pkg::SLAVE_ADDR_V1;
  logic                        mclk;
  logic                        rst_n;
  logic                        scl, h_sda, sda_o, sda_oe;
  logic [sdcp_pkg::CODE_W-1:0] code;
  logic                        upd, pd, ref_sel, sync;
  int                          err_total = 0;
  int                          comparisons = 0;
  int                          cyc = 0;
  int                          upd_cnt = 0;
  wire logic                   sda = h_sda & ~(sda_oe & ~sda_o);

  sdcp_top #(.VARIANT(1)) i_dut (
    .MCLK_I(mclk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .DAC_CODE_O(code), .DAC_UPDATE_O(upd),
    .POWER_DOWN_O(pd), .INTERNAL_REF_O(ref_sel), .SYNC_MODE_O(sync)
  );
  sdcp_host i_host (.clk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_o(h_sda));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input logic [15:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic send(input logic [7:0] b);
    logic a;
    i_host.xbyte(b, a);
    chk(a, 1'h1, "ack");
  endtask : send

  task automatic nack(input logic [7:0] b);
    logic a;
    i_host.xbyte(b, a);
    chk(a, 1'h0, "nack");
  endtask : nack

  task automatic word(input logic [7:0] c, lo, hi);
    i_host.start();
    send({ADDR, sdcp_pkg::RW_WRITE});
    send(c);
    send(lo);
    send(hi);
    i_host.stop();
  endtask : word

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_word();
    chk({code, pd, ref_sel, sync, sda_oe}, 16'h0, "reset");
    word(8'hFC, 8'hA5, 8'hFE);
    chk(code, 10'h2A5, "code");
    chk({ref_sel, pd, sync}, 3'h4, "cmd");
    $display("test word finished");
  endtask : t_word

  task automatic t_send();
    i_host.start();
    send({ADDR, sdcp_pkg::RW_WRITE});
    send(8'h02);
    chk(pd, 1'h0, "pd early");
    i_host.stop();
    chk({ref_sel, pd, sync}, 3'h2, "pd");
    chk(code, 10'h2A5, "data kept");
    $display("test send finished");
  endtask : t_send

  task automatic t_abort();
    i_host.start();
    send({ADDR, sdcp_pkg::RW_WRITE});
    send(8'h00);
    send(8'h11);
    i_host.stop();
    chk({code, pd}, {10'h2A5, 1'h0}, "partial word");
    i_host.start();
    send({ADDR, sdcp_pkg::RW_WRITE});
    repeat (7) i_host.bitx(1'h1);
    i_host.start();
    i_host.stop();
    chk({ref_sel, pd, sync}, 3'h0, "partial cmd");
    $display("test abort finished");
  endtask : t_abort

  task automatic t_sync();
    int n;
    n = upd_cnt;
    word(8'h01, 8'h33, 8'h01);
    chk(code, 10'h2A5, "held");
    i_host.start();
    send({sdcp_pkg::SYNC_ADDR, 1'h1});
    chk(code, 10'h133, "sync update");
    i_host.stop();
    chk(upd_cnt - n, 16'h1, "one pulse in sync mode");
    $display("test sync finished");
  endtask : t_sync

  task automatic t_clear();
    int n;
    word(8'h06, 8'h77, 8'h03);
    chk({code, ref_sel, pd}, {10'h377, 2'h3}, "pre clear");
    n = upd_cnt;
    i_host.start();
    send({sdcp_pkg::SYNC_ADDR, sdcp_pkg::ACTION_CLEAR});
    chk({code, ref_sel, pd, sync}, 13'h0, "clear");
    chk(upd_cnt, n, "no pulse at clear");
    i_host.stop();
    chk(code, 10'h0, "input cleared");
    $display("test clear finished");
  endtask : t_clear

  task automatic t_foreign();
    i_host.start();
    nack({sdcp_pkg::SLAVE_ADDR_V0, 1'h0});
    nack(8'h04);
    i_host.start();
    nack({ADDR, 1'h1});
    i_host.stop();
    chk({ref_sel, pd, sync}, 3'h0, "ignored");
    $display("test foreign finished");
  endtask : t_foreign

  // ************************************************************
  // Run
  // ************************************************************
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // Whole run is near 7400 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (upd === 1'h1) begin
      upd_cnt <= upd_cnt + 1;
    end
    if (cyc == 40000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    rst_n = 1'h0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (3) @(posedge mclk);
    t_word();
    t_send();
    t_abort();
    t_sync();
    t_clear();
    t_foreign();
    summarize();
  end
endmodule : tb

`default_nettype wire
